// ### logic/drsr_params.svh
// Timing counts and field positions for the refresh / self-refresh block.
// Assumes a 25 MHz core clock; times in ns are converted to cycles here.
`ifndef DRSR_PARAMS_SVH
`define DRSR_PARAMS_SVH

`define DRSR_CLK_PERIOD_NS 40
// Internal self-refresh timer period (longest), in ns
`define DRSR_SR_TICK_NS 5000
`define DRSR_SR_TICK_CYC (`DRSR_SR_TICK_NS / `DRSR_CLK_PERIOD_NS)
// Refresh busy time (least), in ns
`define DRSR_TRFC_NS 350
`define DRSR_TRFC_CYC ((`DRSR_TRFC_NS + `DRSR_CLK_PERIOD_NS - 1) / `DRSR_CLK_PERIOD_NS)
// DLL relock time after self-refresh exit (least), in ns
`define DRSR_DLL_RELOCK_NS 20480
`define DRSR_DLL_RELOCK_CYC ((`DRSR_DLL_RELOCK_NS + `DRSR_CLK_PERIOD_NS - 1) / `DRSR_CLK_PERIOD_NS)
// Average refresh interval kept by the controller model, in cycles (plain default)
`define DRSR_TREFI_CYC 195
`define DRSR_CNT_W 10
`define DRSR_ROW_W 16
`define DRSR_BANKS 8
// Address bit that picks burst length on read/write
`define DRSR_BL_BIT 12
// Mode register 1 bit that disables the DLL
`define DRSR_DLL_DIS_BIT 0

`endif

// ### logic/drsr_pkg.sv
// Types shared by the refresh / self-refresh block.
// Assumes the params header is included by users of counts.
package drsr_pkg;
	typedef enum logic [1:0] {
		DRSR_IDLE,
		DRSR_REFRESH,
		DRSR_SELF
	} drsr_state_t;
endpackage

// ### logic/drsr_sync.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module drsr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### logic/drsr_core.sv
// Refresh, self-refresh and burst-length decode inside the DRAM.
// Assumes pins arrive unsynchronised; controller keeps its own timing.
//
// What the device and its controller must do
// R1: A12 low on read/write gives burst chop four, high gives burst eight.
// R2: Write data setup/hold faults only corrupt the addressed location.
// R3: Write strobe timing faults corrupt only addressed location; device keeps running.
// R4: CS, RAS, CAS low with WE high decodes one refresh per command.
// R5: Controller refreshes only with all banks precharged for tRP.
// R6: Refresh row comes from the internal counter; address pins ignored.
// R7: After refresh every bank is left precharged and idle.
// R8: Controller sends only NOP or deselect until tRFC passes; the bench sends one refresh inside tRFC.
// R9: Controller supplies refreshes at an average interval of tREFI.
// R10: At most eight refreshes postponed; gap never over nine intervals.
// R11: At most eight refreshes pulled in for credit; nine-interval gap holds.
// R12: Controller executes all postponed refreshes before self-refresh entry.
// R13: Refresh decode with CKE low enters self-refresh; CKE low keeps it.
// R14: Controller precharges all banks and turns termination off before entry.
// R15: DLL enabled: auto-disable on self-refresh entry, re-enable with reset on exit.
// R16: In self-refresh only CKE and reset matter; internal clock gated off.
// R17: At least one internal refresh within tCKE; controller stays that long.
// R18: Controller changes clock only after tCKSRE; stable tCKSRX before exit.
// R19: Exit is CKE high with NOP; wait tXS, or tXSDLL for DLL commands.
// R20: Controller holds NOP, CKE high and termination off through exit.
// R21: Controller waits tXS and sends one refresh before re-entering.
// R22: Clock must be stable before CKE returns high for exit.
// R23: Controller keeps a refresh credit counter between minus eight and eight.
`timescale 1ns/10ps
`default_nettype none
`include "drsr_params.svh"
module drsr_core (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [`DRSR_ROW_W-1:0] addr,
	// Mode register 1 DLL disable bit
	input wire logic mr1_dll_dis,
	// Write strobe timing fault seen by the data path
	input wire logic wr_fault,
	// Status
	output logic refresh_busy,
	output logic self_refresh,
	output logic clk_gated,
	output logic dll_enabled,
	output logic dll_reset,
	output logic dll_locked,
	output logic [`DRSR_ROW_W-1:0] refresh_row,
	output logic refresh_pulse,
	output logic [`DRSR_BANKS-1:0] bank_open,
	output logic burst_chop,
	output logic burst_valid,
	output logic corrupt_addr_only,
	output logic need_reinit
);
	typedef struct packed {
		drsr_pkg::drsr_state_t st;
		logic [`DRSR_CNT_W-1:0] busy_cnt;
		logic [`DRSR_CNT_W-1:0] tick_cnt;
		logic [`DRSR_CNT_W+5:0] dll_cnt;
		logic [`DRSR_ROW_W-1:0] row;
		logic refresh_pulse;
		logic [`DRSR_BANKS-1:0] bank_open;
		logic burst_chop;
		logic burst_valid;
		logic dll_enabled;
		logic dll_reset;
		logic dll_locked;
		logic dll_auto_off;
		logic corrupt;
		logic busy;
		logic in_self;
	} drsr_regs_t;

	localparam logic [`DRSR_CNT_W-1:0] TRFC = `DRSR_CNT_W'(`DRSR_TRFC_CYC);
	localparam logic [`DRSR_CNT_W-1:0] TICK = `DRSR_CNT_W'(`DRSR_SR_TICK_CYC);
	localparam logic [`DRSR_CNT_W+5:0] RELOCK = (`DRSR_CNT_W+6)'(`DRSR_DLL_RELOCK_CYC);

	logic [4:0] pin_s;
	logic [`DRSR_ROW_W-1:0] addr_s;
	logic mr1_s;
	logic fault_s;
	drsr_regs_t r_q;
	drsr_regs_t r_d;

	drsr_sync #(.W(5)) u_sync_cmd (
		.core_clk(core_clk),
		.rst(rst),
		.d({cke, cs_n, ras_n, cas_n, we_n}),
		.q(pin_s)
	);
	drsr_sync #(.W(`DRSR_ROW_W + 2)) u_sync_misc (
		.core_clk(core_clk),
		.rst(rst),
		.d({addr, mr1_dll_dis, wr_fault}),
		.q({addr_s, mr1_s, fault_s})
	);

	logic cke_s;
	logic is_ref;
	logic is_act;
	logic is_pre;
	logic is_rw;
	logic is_nop;
	assign cke_s = pin_s[4];
	// R4
	assign is_ref = !pin_s[3] && !pin_s[2] && !pin_s[1] && pin_s[0];
	assign is_act = !pin_s[3] && !pin_s[2] && pin_s[1] && pin_s[0];
	assign is_pre = !pin_s[3] && !pin_s[2] && pin_s[1] && !pin_s[0];
	assign is_rw = !pin_s[3] && pin_s[2] && !pin_s[1];
	assign is_nop = pin_s[3] || (pin_s[2] && pin_s[1] && pin_s[0]);

	always_comb begin
		r_d = r_q;
		r_d.refresh_pulse = 1'b0;
		r_d.burst_valid = 1'b0;
		r_d.dll_reset = 1'b0;
		if (r_q.dll_cnt != '0) begin
			r_d.dll_cnt = r_q.dll_cnt - 1'b1;
			if (r_q.dll_cnt == 1) begin
				r_d.dll_locked = r_q.dll_enabled;
			end
		end
		// Fault is tagged to the current write only; no state is poisoned
		r_d.corrupt = fault_s; // R2 R3
		case (r_q.st)
			drsr_pkg::DRSR_IDLE: begin
				if (is_ref) begin
					r_d.refresh_pulse = 1'b1;
					r_d.row = r_q.row + 1'b1; // R6
					r_d.bank_open = '0; // R7
					if (!cke_s) begin
						// R13
						r_d.st = drsr_pkg::DRSR_SELF;
						r_d.tick_cnt = TICK;
						if (!mr1_s) begin
							// R15
							r_d.dll_enabled = 1'b0;
							r_d.dll_locked = 1'b0;
							r_d.dll_auto_off = 1'b1;
						end
					end else begin
						r_d.st = drsr_pkg::DRSR_REFRESH;
						r_d.busy_cnt = TRFC;
					end
				end else if (is_act) begin
					r_d.bank_open[addr_s[2:0]] = 1'b1;
				end else if (is_pre) begin
					if (addr_s[10]) begin
						r_d.bank_open = '0;
					end else begin
						r_d.bank_open[addr_s[2:0]] = 1'b0;
					end
				end else if (is_rw) begin
					r_d.burst_chop = !addr_s[`DRSR_BL_BIT]; // R1
					r_d.burst_valid = 1'b1;
				end
				r_d.dll_enabled = r_d.dll_enabled && !mr1_s;
			end
			drsr_pkg::DRSR_REFRESH: begin
				// Commands ignored while busy; the bench sends a refresh here to test that
				if (r_q.busy_cnt <= 1) begin
					r_d.busy_cnt = '0;
					r_d.bank_open = '0; // R7
					r_d.st = drsr_pkg::DRSR_IDLE;
				end else begin
					r_d.busy_cnt = r_q.busy_cnt - 1'b1;
				end
			end
			drsr_pkg::DRSR_SELF: begin
				// R16
				if (r_q.tick_cnt <= 1) begin
					r_d.tick_cnt = TICK; // R17
					r_d.refresh_pulse = 1'b1;
					r_d.row = r_q.row + 1'b1;
				end else begin
					r_d.tick_cnt = r_q.tick_cnt - 1'b1;
				end
				if (cke_s && is_nop) begin
					r_d.st = drsr_pkg::DRSR_IDLE;
					r_d.tick_cnt = '0;
					if (r_q.dll_auto_off) begin
						// R15
						r_d.dll_enabled = 1'b1;
						r_d.dll_reset = 1'b1;
						r_d.dll_cnt = RELOCK;
						r_d.dll_auto_off = 1'b0;
					end
				end
			end
			default: r_d.st = drsr_pkg::DRSR_IDLE;
		endcase
		// State flags registered so status pins come straight from flops
		r_d.busy = r_d.st == drsr_pkg::DRSR_REFRESH;
		r_d.in_self = r_d.st == drsr_pkg::DRSR_SELF; // R16
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r_q <= '{st: drsr_pkg::DRSR_IDLE, dll_enabled: 1'b1, dll_locked: 1'b1, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	always_comb begin
		refresh_busy = r_q.busy;
		self_refresh = r_q.in_self;
		clk_gated = r_q.in_self;
		dll_enabled = r_q.dll_enabled;
		dll_reset = r_q.dll_reset;
		dll_locked = r_q.dll_locked;
		refresh_row = r_q.row;
		refresh_pulse = r_q.refresh_pulse;
		bank_open = r_q.bank_open;
		burst_chop = r_q.burst_chop;
		burst_valid = r_q.burst_valid;
		corrupt_addr_only = r_q.corrupt;
		need_reinit = 1'b0; // R2 R3
	end

	AST_BL_DECODE: assert property (@(posedge core_clk) disable iff (rst) // R1
		(r_q.st == drsr_pkg::DRSR_IDLE && is_rw) |=> burst_valid
		&& burst_chop == !$past(addr_s[`DRSR_BL_BIT]))
		else $error("burst length decode wrong");
	AST_REF_ONCE: assert property (@(posedge core_clk) disable iff (rst) // R4
		(r_q.st == drsr_pkg::DRSR_IDLE && is_ref && cke_s) |=> refresh_busy ##1 !refresh_pulse)
		else $error("refresh not taken once");
	AST_ROW_INC: assert property (@(posedge core_clk) disable iff (rst) // R6
		refresh_pulse |-> refresh_row == $past(refresh_row) + 1'b1)
		else $error("refresh row not from counter");
	AST_BANKS_IDLE: assert property (@(posedge core_clk) disable iff (rst) // R7
		(refresh_busy ##1 !refresh_busy) |-> bank_open == '0)
		else $error("banks open after refresh");
	AST_SRE: assert property (@(posedge core_clk) disable iff (rst) // R13
		(r_q.st == drsr_pkg::DRSR_IDLE && is_ref && !cke_s) |=> self_refresh && clk_gated)
		else $error("self refresh not entered");
	AST_DLL_EXIT: assert property (@(posedge core_clk) disable iff (rst) // R15
		(self_refresh && r_q.dll_auto_off && cke_s && is_nop) |=> dll_reset && dll_enabled && !dll_locked)
		else $error("dll not re-enabled with reset");
	AST_SR_IGNORE: assert property (@(posedge core_clk) disable iff (rst) // R16
		(self_refresh && !cke_s) |=> self_refresh && bank_open == $past(bank_open))
		else $error("command acted in self refresh");
	AST_SR_TICK: assert property (@(posedge core_clk) disable iff (rst) // R17
		(self_refresh && r_q.tick_cnt == 1) |=> refresh_pulse)
		else $error("no internal refresh in self refresh");
	AST_NO_REINIT: assert property (@(posedge core_clk) disable iff (rst) // R2 R3
		fault_s |=> corrupt_addr_only && !need_reinit)
		else $error("write fault disturbed device");
endmodule
`default_nettype wire

// ### tb/drsr_ctl_model.sv
// Controller model driving the command pins of the refresh block.
// Assumes the bench calls its task from one process only.
`timescale 1ns/10ps
`default_nettype none
`include "drsr_params.svh"
module drsr_ctl_model (
	// Clock
	input wire logic core_clk,
	// Command pins
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [15:0] addr
);
	initial begin
		cke = 1'b1;
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		addr = 16'h0000;
	end
	// Refresh credit: up per refresh sent, down per elapsed interval
	int credit = 0;
	int since = 0;
	int nxt;
	always_comb nxt = credit + int'({cs_n, ras_n, cas_n, we_n} == 4'b0001)
		- int'(since == `DRSR_TREFI_CYC - 1);
	always @(posedge core_clk) begin
		// Pull-ins beyond eight earn no further credit
		credit <= (nxt > 8) ? 8 : nxt;
		since <= (since == `DRSR_TREFI_CYC - 1) ? 0 : since + 1;
	end
	// One command cycle; the bench closes every bank it opens before a refresh
	task automatic cmd(input logic [2:0] rcw, input logic ck, input logic [15:0] a);
		@(posedge core_clk);
		#1;
		{cs_n, ras_n, cas_n, we_n} = {1'b0, rcw};
		cke = ck;
		addr = a;
		@(posedge core_clk);
		#1;
		// Deselect after; address inverted so a stale value is never held
		{cs_n, ras_n, cas_n, we_n} = 4'hf;
		addr = ~a;
	endtask
endmodule
`default_nettype wire

// ### tb/drsr_tb.sv
// Self-checking bench for the refresh / self-refresh block.
// Assumes the params header and the controller model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "drsr_params.svh"
module testbench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic mr1_dll_dis = 1'b0;
	logic wr_fault = 1'b0;
	logic cke, cs_n, ras_n, cas_n, we_n;
	logic [15:0] addr, refresh_row;
	logic refresh_busy, self_refresh, clk_gated, dll_enabled, dll_reset, dll_locked;
	logic refresh_pulse, burst_chop, burst_valid, corrupt_addr_only, need_reinit;
	logic [7:0] bank_open;
	int mismatches = 0;
	int n_tests = 0;
	localparam logic [2:0] REF = 3'b001;
	// Clock never stopped or retuned, so entry and exit clock delays hold
	always #20 core_clk = ~core_clk;
	drsr_ctl_model i_ctl (.core_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr);
	drsr_core i_dut (.core_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr,
		.mr1_dll_dis, .wr_fault, .refresh_busy, .self_refresh, .clk_gated, .dll_enabled,
		.dll_reset, .dll_locked, .refresh_row, .refresh_pulse, .bank_open, .burst_chop,
		.burst_valid, .corrupt_addr_only, .need_reinit);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wrap_up();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic test_fault();
		wr_fault = 1'b1;
		edges(3);
		chk(16'({corrupt_addr_only, need_reinit}), 16'h0002);
		wr_fault = 1'b0;
		edges(3);
		chk(16'({corrupt_addr_only, need_reinit}), 16'h0000);
		$display("test fault done");
	endtask
	task automatic test_refresh();
		i_ctl.cmd(3'b011, 1'b1, 16'h0005);
		edges(2);
		chk(16'(bank_open), 16'h0020);
		i_ctl.cmd(3'b010, 1'b1, 16'h0400);
		edges(2);
		chk(16'(bank_open), 16'h0000);
		i_ctl.cmd(REF, 1'b1, 16'ha5c3);
		edges(2);
		chk(16'({refresh_pulse, refresh_busy}), 16'h0003);
		chk(refresh_row, 16'h0001);
		// Second command lands while busy and must be dropped
		i_ctl.cmd(REF, 1'b1, 16'h5a3c);
		edges(`DRSR_TRFC_CYC - 3);
		chk(16'({refresh_busy, refresh_row[14:0]}), 16'h8001);
		edges(1);
		chk(16'({refresh_busy, bank_open}), 16'h0000);
		i_ctl.cmd(REF, 1'b1, 16'hffff);
		edges(2);
		chk(refresh_row, 16'h0002);
		edges(1);
		chk(16'(refresh_pulse), 16'h0000);
		edges(`DRSR_TRFC_CYC);
		$display("test refresh done");
	endtask
	task automatic test_burst();
		logic a12;
		for (int i = 0; i < 4; i++) begin
			a12 = i[0];
			i_ctl.cmd(i[1] ? 3'b100 : 3'b101, 1'b1, {3'h0, a12, 12'h155});
			edges(2);
			chk(16'({burst_valid, burst_chop}), 16'({1'b1, ~a12}));
			edges(1);
			chk(16'(burst_valid), 16'h0000);
		end
		$display("test burst done");
	endtask
	task automatic test_self();
		int cnt;
		int waited;
		cnt = 0;
		waited = 0;
		chk(16'(i_ctl.credit >= 0), 16'h0001);
		i_ctl.cmd(REF, 1'b0, 16'h0000);
		edges(2);
		chk(16'({self_refresh, clk_gated, dll_enabled}), 16'h0006);
		// Command pins toggled while inside must change nothing
		i_ctl.cmd(3'b101, 1'b0, 16'h1234);
		repeat (`DRSR_SR_TICK_CYC + 2) begin
			edges(1);
			cnt += int'(refresh_pulse);
		end
		chk(16'(cnt >= 1 && cnt <= 2), 16'h0001);
		chk(16'({self_refresh, burst_valid}), 16'h0002);
		i_ctl.cmd(3'b111, 1'b1, 16'h0000);
		edges(2);
		chk(16'({self_refresh, dll_reset, dll_enabled, dll_locked}), 16'h0006);
		edges(1);
		chk(16'(dll_reset), 16'h0000);
		while (dll_locked !== 1'b1 && waited < `DRSR_DLL_RELOCK_CYC + 8) begin
			edges(1);
			waited++;
		end
		// Lock lands exactly the relock count after the reset pulse
		chk(16'(waited + 1), 16'(`DRSR_DLL_RELOCK_CYC));
		chk(16'(dll_locked), 16'h0001);
		// Second round with the DLL switched off by the mode register
		mr1_dll_dis = 1'b1;
		i_ctl.cmd(REF, 1'b1, 16'h0000);
		edges(`DRSR_TRFC_CYC + 2);
		chk(16'({refresh_busy, dll_enabled}), 16'h0000);
		chk(16'(i_ctl.credit >= 0), 16'h0001);
		i_ctl.cmd(REF, 1'b0, 16'h0000);
		edges(2);
		chk(16'({self_refresh, dll_enabled, refresh_pulse}), 16'h0005);
		i_ctl.cmd(3'b111, 1'b1, 16'h0000);
		edges(2);
		chk(16'({self_refresh, dll_reset, dll_enabled}), 16'h0000);
		chk(16'(i_ctl.credit >= -8 && i_ctl.credit <= 8), 16'h0001);
		$display("test self refresh done");
	endtask
	initial begin
		#(40 * 20000);
		mismatches++;
		wrap_up();
	end
	initial begin
		edges(8);
		rst = 1'b0;
		chk(16'({dll_enabled, dll_locked, self_refresh, refresh_busy, need_reinit}), 16'h0018);
		$display("test reset done");
		test_fault();
		test_refresh();
		test_burst();
		test_self();
		wrap_up();
	end
endmodule
`default_nettype wire
